// [logic/bco_object_ctrl.sv]
// Purpose: control and monitoring of one switchgear object
// Assumes: settings in 20 ms ticks, one request handled at a time
// Notes:   requests are taken on rising edges of the merged command sources
`timescale 1ns/10ps
module bco_object_ctrl #(
    parameter int TICK_CYCLES = bco_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    // digital inputs from the object and operator
    input  wire bco_pkg::bco_pins_t pins,
    // application and panel commands, same clock
    input  wire logic              app_open,
    input  wire logic              app_close,
    input  wire logic              panel_single_line_control_open,
    input  wire logic              panel_single_line_control_close,
    input  wire logic [1:0]        panel_level,
    input  wire logic              reclose_pending,
    // relays and status
    output logic                   open_relay,
    output logic                   close_relay,
    output logic                   final_trip,
    output logic                   timeout_event,
    output logic      [1:0]        breaker_status,
    output logic      [2:0]        cart_status
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        bco_pkg::bco_phase_t phase;
        logic [TW-1:0]       tick_cnt;
        logic                tick;
        logic [7:0]          cfg;
        logic [15:0]         trav_set;
        logic [15:0]         close_set;
        logic [15:0]         open_set;
        logic [15:0]         term_set;
        logic [15:0]         ft_set;
        logic                clr;
        logic [31:0]         ok_open;
        logic [31:0]         ok_close;
        logic [31:0]         fail_open;
        logic [31:0]         fail_close;
        logic [15:0]         trav_cnt;
        logic [15:0]         pulse_cnt;
        logic [15:0]         term_cnt;
        logic [15:0]         ft_cnt;
        logic                open_req_d;
        logic                close_req_d;
        logic                open_relay;
        logic                close_relay;
        logic                final_trip;
        logic                timeout_event;
        logic [1:0]          brk;
        logic [2:0]          cart;
        logic [31:0]         rdata;
    } bco_st_t;

    localparam bco_st_t ST_RESET = '{
        phase:     bco_pkg::PH_IDLE,
        cfg:       bco_pkg::CFG_RESET,
        trav_set:  bco_pkg::TRAVERSE_TICKS,
        close_set: bco_pkg::CLOSE_MAX_TICKS,
        open_set:  bco_pkg::OPEN_MAX_TICKS,
        term_set:  bco_pkg::TERMINATE_TICKS,
        ft_set:    bco_pkg::FINAL_TRIP_TICKS,
        default:   '0
    };

    bco_st_t            s;
    bco_st_t            next_s;
    logic [12:0]        pf_vec;
    bco_pkg::bco_pins_t pf;

    bco_sync #(
        .W($bits(bco_pkg::bco_pins_t))
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (pins),
        .dout (pf_vec)
    );
    assign pf = bco_pkg::bco_pins_t'(pf_vec);

    // saturating increment keeps counters pinned at the top rather than wrapping
    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h00000001;
    endfunction

    function automatic logic [31:0] read_mux(input logic [7:0] a, input bco_st_t st);
        case (a)
            bco_pkg::ADDR_CONFIG:     read_mux = {24'h000000, st.cfg};
            bco_pkg::ADDR_TRAVERSE:   read_mux = {16'h0000, st.trav_set};
            bco_pkg::ADDR_CLOSE_MAX:  read_mux = {16'h0000, st.close_set};
            bco_pkg::ADDR_OPEN_MAX:   read_mux = {16'h0000, st.open_set};
            bco_pkg::ADDR_TERMINATE:  read_mux = {16'h0000, st.term_set};
            bco_pkg::ADDR_FINAL_TRIP: read_mux = {16'h0000, st.ft_set};
            bco_pkg::ADDR_CLEAR:      read_mux = {31'h00000000, st.clr};
            bco_pkg::ADDR_STATUS:     read_mux = {16'h0000, pf_vec[12:8], st.cart, st.brk,
                                                  st.final_trip, st.close_relay, st.open_relay, st.phase};
            bco_pkg::ADDR_OPEN_OK:    read_mux = st.ok_open;
            bco_pkg::ADDR_CLOSE_OK:   read_mux = st.ok_close;
            bco_pkg::ADDR_OPEN_FAIL:  read_mux = st.fail_open;
            bco_pkg::ADDR_CLOSE_FAIL: read_mux = st.fail_close;
            default:                  read_mux = 32'h00000000;
        endcase
    endfunction

    bco_pkg::bco_obj_t obj_type;
    logic              brk_type;
    logic              is_open;
    logic              is_closed;
    logic              ready_ok;
    logic              close_ok;
    logic              lvl_ok;
    logic              open_req;
    logic              close_req;
    logic              open_rise;
    logic              close_rise;
    logic              inc_ok_open;
    logic              inc_ok_close;
    logic              rej_open;
    logic              rej_close;

    always_comb begin
        obj_type  = bco_pkg::bco_obj_t'(s.cfg[bco_pkg::CFG_TYPE_LSB +: 2]);
        brk_type  = (obj_type == bco_pkg::OBJ_WITHDRAW) || (obj_type == bco_pkg::OBJ_BREAKER);
        is_open   = pf.open_st & ~pf.close_st;
        is_closed = pf.close_st & ~pf.open_st;
        case (s.cfg[bco_pkg::CFG_READY_LSB +: 2])
            bco_pkg::RDY_HIGH: ready_ok = pf.ready;
            bco_pkg::RDY_LOW:  ready_ok = ~pf.ready;
            default:           ready_ok = 1'b1;
        endcase
        // ready, sync and earth interlock only guard breaker types
        close_ok = ~pf.block_close
                   & ~(brk_type & pf.earth_closed)
                   & (~brk_type | ready_ok)
                   & (~brk_type | ~s.cfg[bco_pkg::CFG_SYNC_BIT] | pf.sync_ok);
        lvl_ok    = panel_level >= s.cfg[bco_pkg::CFG_LEVEL_LSB +: 2];
        open_req  = pf.local_open | pf.remote_open | app_open
                    | (panel_single_line_control_open & lvl_ok);
        close_req = pf.local_close | pf.remote_close | app_close
                    | (panel_single_line_control_close & lvl_ok);
        open_rise  = open_req & ~s.open_req_d;
        close_rise = close_req & ~s.close_req_d;
    end

    always_comb begin
        next_s = s;
        next_s.timeout_event = 1'b0;
        next_s.rdata = 32'h00000000;
        next_s.open_req_d = open_req;
        next_s.close_req_d = close_req;
        inc_ok_open = 1'b0;
        inc_ok_close = 1'b0;
        rej_open = 1'b0;
        rej_close = 1'b0;

        // system tick
        next_s.tick = 1'b0;
        if (s.tick_cnt == TW'(TICK_CYCLES - 1)) begin
            next_s.tick_cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 1'b1;
        end

        // breaker position with traverse delay before bad or intermediate
        if (is_open | is_closed) begin
            next_s.trav_cnt = 16'h0000;
            next_s.brk = is_open ? bco_pkg::BRK_OPEN : bco_pkg::BRK_CLOSED;
        end else if (s.trav_cnt >= s.trav_set) begin
            next_s.brk = pf.open_st ? bco_pkg::BRK_BAD : bco_pkg::BRK_INTER;
        end else if (s.tick) begin
            next_s.trav_cnt = s.trav_cnt + 1'b1;
        end

        // cart position only for withdrawable objects
        if (obj_type != bco_pkg::OBJ_WITHDRAW) begin
            next_s.cart = bco_pkg::CART_UNUSED;
        end else begin
            case ({pf.cart_racked_in_input, pf.cart_pulled_out_input})
                2'b10:   next_s.cart = bco_pkg::CART_IN;
                2'b01:   next_s.cart = bco_pkg::CART_OUT;
                2'b11:   next_s.cart = bco_pkg::CART_BAD;
                default: next_s.cart = bco_pkg::CART_INTER;
            endcase
        end

        // final trip length
        if (s.final_trip && s.ft_set != 16'h0000) begin
            if (s.ft_cnt >= s.ft_set) begin
                next_s.final_trip = 1'b0;
            end else if (s.tick) begin
                next_s.ft_cnt = s.ft_cnt + 1'b1;
            end
        end

        case (s.phase)
            bco_pkg::PH_IDLE: begin
                // an earth switch takes no command at all
                if (obj_type != bco_pkg::OBJ_EARTH && open_rise) begin
                    if (pf.block_open) begin
                        rej_open = 1'b1;
                    end else begin
                        next_s.phase = bco_pkg::PH_OPEN;
                        next_s.open_relay = 1'b1;
                        next_s.pulse_cnt = 16'h0000;
                        next_s.term_cnt = 16'h0000;
                    end
                end else if (obj_type != bco_pkg::OBJ_EARTH && close_rise) begin
                    if (!close_ok) begin
                        rej_close = 1'b1;
                    end else begin
                        next_s.phase = bco_pkg::PH_CLOSE;
                        next_s.close_relay = 1'b1;
                        next_s.pulse_cnt = 16'h0000;
                        next_s.term_cnt = 16'h0000;
                    end
                end
            end
            bco_pkg::PH_OPEN: begin
                if (is_open) begin
                    next_s.open_relay = 1'b0;
                    next_s.phase = bco_pkg::PH_IDLE;
                    inc_ok_open = 1'b1;
                    if (!reclose_pending) begin
                        next_s.final_trip = 1'b1;
                        next_s.ft_cnt = 16'h0000;
                    end
                end else if (s.term_cnt >= s.term_set) begin
                    next_s.open_relay = 1'b0;
                    next_s.phase = bco_pkg::PH_IDLE;
                    next_s.timeout_event = 1'b1;
                    rej_open = 1'b1;
                end else begin
                    if (s.pulse_cnt >= s.open_set) begin
                        next_s.open_relay = 1'b0;
                    end
                    if (s.tick) begin
                        next_s.pulse_cnt = s.pulse_cnt + 1'b1;
                        next_s.term_cnt = s.term_cnt + 1'b1;
                    end
                end
            end
            bco_pkg::PH_CLOSE: begin
                if (is_closed) begin
                    next_s.close_relay = 1'b0;
                    next_s.phase = bco_pkg::PH_IDLE;
                    next_s.final_trip = 1'b0;
                    inc_ok_close = 1'b1;
                end else if (s.term_cnt >= s.term_set) begin
                    next_s.close_relay = 1'b0;
                    next_s.phase = bco_pkg::PH_IDLE;
                    next_s.timeout_event = 1'b1;
                    rej_close = 1'b1;
                end else begin
                    if (s.pulse_cnt >= s.close_set) begin
                        next_s.close_relay = 1'b0;
                    end
                    if (s.tick) begin
                        next_s.pulse_cnt = s.pulse_cnt + 1'b1;
                        next_s.term_cnt = s.term_cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_s.phase = bco_pkg::PH_IDLE;
                next_s.open_relay = 1'b0;
                next_s.close_relay = 1'b0;
            end
        endcase

        // statistics; a pending clear takes the cycle and then returns itself
        if (s.clr) begin
            next_s.clr = 1'b0;
            next_s.ok_open = 32'h00000000;
            next_s.ok_close = 32'h00000000;
            next_s.fail_open = 32'h00000000;
            next_s.fail_close = 32'h00000000;
        end else begin
            if (inc_ok_open) next_s.ok_open = sat_inc(s.ok_open);
            if (inc_ok_close) next_s.ok_close = sat_inc(s.ok_close);
            if (rej_open) next_s.fail_open = sat_inc(s.fail_open);
            if (rej_close) next_s.fail_close = sat_inc(s.fail_close);
        end

        if (wr) begin
            case (addr)
                bco_pkg::ADDR_CONFIG:     next_s.cfg = wdata[7:0];
                bco_pkg::ADDR_TRAVERSE:   next_s.trav_set = wdata[15:0];
                bco_pkg::ADDR_CLOSE_MAX:  next_s.close_set = wdata[15:0];
                bco_pkg::ADDR_OPEN_MAX:   next_s.open_set = wdata[15:0];
                bco_pkg::ADDR_TERMINATE:  next_s.term_set = wdata[15:0];
                bco_pkg::ADDR_FINAL_TRIP: next_s.ft_set = wdata[15:0];
                bco_pkg::ADDR_CLEAR:      if (wdata[0]) next_s.clr = 1'b1;
                default:                  next_s.clr = next_s.clr;
            endcase
        end
        if (rd) begin
            next_s.rdata = read_mux(addr, s);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= ST_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign rdata          = s.rdata;
    assign open_relay     = s.open_relay;
    assign close_relay    = s.close_relay;
    assign final_trip     = s.final_trip;
    assign timeout_event  = s.timeout_event;
    assign breaker_status = s.brk;
    assign cart_status    = s.cart;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_close_start;
        $rose(s.close_relay);
    endsequence

    sequence seq_open_start;
        $rose(s.open_relay);
    endsequence

    a_relays_exclusive: assert property (!(s.open_relay && s.close_relay))
        else $error("open and close relays active together");
    a_earth_no_cmd: assert property ((seq_close_start or seq_open_start)
        |-> $past(obj_type) != bco_pkg::OBJ_EARTH)
        else $error("earth switch was commanded");
    a_close_early_end: assert property (s.phase == bco_pkg::PH_CLOSE && is_closed |=> !s.close_relay)
        else $error("close pulse kept after object closed");
    a_open_early_end: assert property (s.phase == bco_pkg::PH_OPEN && is_open |=> !s.open_relay)
        else $error("open pulse kept after object opened");
    a_close_max_len: assert property (s.phase == bco_pkg::PH_CLOSE && s.pulse_cnt >= s.close_set
        |=> !s.close_relay)
        else $error("close pulse longer than its maximum");
    a_earth_interlock: assert property (seq_close_start
        |-> !$past(brk_type && pf.earth_closed))
        else $error("breaker closed against closed earth switch");
    a_sync_gate: assert property (seq_close_start and $past(brk_type && s.cfg[bco_pkg::CFG_SYNC_BIT])
        |-> $past(pf.sync_ok))
        else $error("close without synchrocheck permission");
    a_clear_done: assert property (s.clr && !(wr && addr == bco_pkg::ADDR_CLEAR)
        |=> !s.clr && s.ok_open == 32'h00000000 && s.fail_close == 32'h00000000)
        else $error("clear did not zero counters or return");
    a_fail_count: assert property (rej_open && !s.clr && s.fail_open != 32'hFFFFFFFF
        |=> s.fail_open == $past(s.fail_open) + 32'h00000001)
        else $error("failed open request not counted");
    a_timeout_end: assert property (s.timeout_event |-> s.phase == bco_pkg::PH_IDLE
        && !s.open_relay && !s.close_relay)
        else $error("control not ended on timeout");
    a_final_trip_cause: assert property ($rose(s.final_trip)
        |-> $past(s.phase == bco_pkg::PH_OPEN) && !$past(reclose_pending))
        else $error("final trip without a final open");
endmodule

// [logic/bco_pkg.sv]
// Purpose: shared constants and types for the switchgear object controller
// Assumes: 125 MHz system clock, all settings held in 20 ms ticks
// Notes:   register offsets are byte addresses on the plain register port
package bco_pkg;
    // clock and tick timing
    localparam int CLK_KHZ       = 125000;
    localparam int TICK_MS       = 20;
    localparam int TICK_CYCLES   = TICK_MS * CLK_KHZ;

    // default times in milliseconds, and the same in ticks
    localparam int TRAVERSE_MS   = 200;
    localparam int CLOSE_MAX_MS  = 200;
    localparam int OPEN_MAX_MS   = 200;
    localparam int TERMINATE_MS  = 10000;
    localparam int FINAL_TRIP_MS = 200;
    localparam logic [15:0] TRAVERSE_TICKS   = 16'(TRAVERSE_MS / TICK_MS);
    localparam logic [15:0] CLOSE_MAX_TICKS  = 16'(CLOSE_MAX_MS / TICK_MS);
    localparam logic [15:0] OPEN_MAX_TICKS   = 16'(OPEN_MAX_MS / TICK_MS);
    localparam logic [15:0] TERMINATE_TICKS  = 16'(TERMINATE_MS / TICK_MS);
    localparam logic [15:0] FINAL_TRIP_TICKS = 16'(FINAL_TRIP_MS / TICK_MS);

    // register byte offsets
    localparam logic [7:0] ADDR_CONFIG     = 8'h00;
    localparam logic [7:0] ADDR_TRAVERSE   = 8'h04;
    localparam logic [7:0] ADDR_CLOSE_MAX  = 8'h08;
    localparam logic [7:0] ADDR_OPEN_MAX   = 8'h0C;
    localparam logic [7:0] ADDR_TERMINATE  = 8'h10;
    localparam logic [7:0] ADDR_FINAL_TRIP = 8'h14;
    localparam logic [7:0] ADDR_CLEAR      = 8'h18;
    localparam logic [7:0] ADDR_STATUS     = 8'h1C;
    localparam logic [7:0] ADDR_OPEN_OK    = 8'h20;
    localparam logic [7:0] ADDR_CLOSE_OK   = 8'h24;
    localparam logic [7:0] ADDR_OPEN_FAIL  = 8'h28;
    localparam logic [7:0] ADDR_CLOSE_FAIL = 8'h2C;

    // config register field positions
    localparam int CFG_TYPE_LSB  = 0;
    localparam int CFG_SYNC_BIT  = 2;
    localparam int CFG_READY_LSB = 3;
    localparam int CFG_LEVEL_LSB = 5;

    typedef enum logic [1:0] {
        OBJ_WITHDRAW = 2'h0,
        OBJ_BREAKER  = 2'h1,
        OBJ_DISC_MC  = 2'h2,
        OBJ_EARTH    = 2'h3
    } bco_obj_t;

    localparam logic [1:0] RDY_OFF  = 2'h0;
    localparam logic [1:0] RDY_HIGH = 2'h1;
    localparam logic [1:0] RDY_LOW  = 2'h2;

    // access levels: user, operator, configurator, super user
    localparam logic [1:0] LVL_CONFIG = 2'h2;

    localparam logic [1:0] BRK_INTER  = 2'h0;
    localparam logic [1:0] BRK_OPEN   = 2'h1;
    localparam logic [1:0] BRK_CLOSED = 2'h2;
    localparam logic [1:0] BRK_BAD    = 2'h3;

    localparam logic [2:0] CART_INTER  = 3'h0;
    localparam logic [2:0] CART_OUT    = 3'h1;
    localparam logic [2:0] CART_IN     = 3'h2;
    localparam logic [2:0] CART_BAD    = 3'h3;
    localparam logic [2:0] CART_UNUSED = 3'h4;

    // breaker type, no synchrocheck, no ready check, configurator level
    localparam logic [7:0] CFG_RESET = 8'h41;

    typedef enum logic [2:0] {
        PH_IDLE  = 3'b001,
        PH_OPEN  = 3'b010,
        PH_CLOSE = 3'b100
    } bco_phase_t;

    // digital input bundle, all asynchronous to clk
    typedef struct packed {
        logic open_st;
        logic close_st;
        logic cart_racked_in_input;
        logic cart_pulled_out_input;
        logic ready;
        logic sync_ok;
        logic local_open;
        logic local_close;
        logic remote_open;
        logic remote_close;
        logic block_open;
        logic block_close;
        logic earth_closed;
    } bco_pins_t;
endpackage

// [logic/bco_sync.sv]
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous levels
// Notes:   output changes only once the second and third stages agree
`timescale 1ns/10ps
module bco_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // raw levels and filtered levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bco_sync_st_t;

    bco_sync_st_t s;
    bco_sync_st_t next_s;

    always_comb begin
        next_s.s1 = din;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        // first stage feeds only the second; the filter looks at stages two and three
        next_s.q  = (s.s2 & s.s3) | (s.q & (s.s2 | s.s3));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.q;
endmodule

// [verification/bco_breaker_model.sv]
// Purpose: behavioural breaker answering the relays
// Assumes: contacts move dly cycles after a relay rises
// Notes:   stuck models a jammed mechanism
`timescale 1ns/10ps
module bco_breaker_model (
    // clock and control
    input  wire logic       clk,
    input  wire logic       stuck,
    input  wire logic [7:0] dly,
    // relays in, contacts out
    input  wire logic       open_relay,
    input  wire logic       close_relay,
    output logic            open_st,
    output logic            close_st
);
    logic [7:0] cnt = 8'h00;
    initial begin
        open_st = 1'b0;
        close_st = 1'b1;
    end
    always @(posedge clk) begin
        cnt <= (open_relay || close_relay) && !stuck ? cnt + 8'h01 : 8'h00;
        if (cnt == dly && (open_relay || close_relay) && !stuck) begin
            open_st <= open_relay;
            close_st <= close_relay;
        end
    end
endmodule

// [verification/bco_object_ctrl_test.sv]
// Purpose: self-checking bench for the object controller
// Assumes: tick shortened to 10 cycles
// Notes:   contact delay is random for each of the first nine commands, then held
`timescale 1ns/10ps
module bco_object_ctrl_test;
    logic        clk, rst, wr, rd, stuck, oc, cc, orl, crl, ft;
    logic [2:0]  cs;
    wire         tev;
    logic [7:0]  addr, dly;
    logic [31:0] wdata, v;
    wire  [31:0] rdata;
    logic [10:0] pn;
    logic [1:0]  ap, pm, bs;
    int          bad_count, n_tests, n_to;
    int          e [4];
    int          tb [4] = '{1, 0, 7, 8};
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    bco_object_ctrl #(.TICK_CYCLES(10)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pins({oc, cc, pn}), .app_open(ap[0]), .app_close(ap[1]),
        .panel_single_line_control_open(pm[0]), .panel_single_line_control_close(pm[1]),
        .panel_level(2'h3), .reclose_pending(1'b0), .open_relay(orl), .close_relay(crl), .final_trip(ft),
        .timeout_event(tev), .breaker_status(bs), .cart_status(cs));
    bco_breaker_model mdl (.clk(clk), .stuck(stuck), .dly(dly), .open_relay(orl), .close_relay(crl),
        .open_st(oc), .close_st(cc));
    always @(posedge clk) if (tev === 1'b1) n_to++;
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", s, x, g);
        end
    endtask
    task automatic cnts;
        for (int i = 0; i < 4; i++) begin
            rd_reg(bco_pkg::ADDR_OPEN_OK + 8'(4 * i), v);
            chk("counter", e[i], v);
        end
        $display("test done, %0d checks", n_tests);
    endtask
    function automatic logic [1:0] exp_brk(input int c);
        return c ? bco_pkg::BRK_CLOSED : bco_pkg::BRK_OPEN;
    endfunction
    task automatic cmd(input int k, input int c);
        repeat (8) @(posedge clk);
        if (k < 2) pn[6 - 2 * k - c] <= 1'b1;
        else if (k == 2) ap[c] <= 1'b1;
        else pm[c] <= 1'b1;
        repeat (8) @(posedge clk);
        pn[6:3] <= 4'h0;
        ap <= 2'b00;
        pm <= 2'b00;
        for (int i = 0; i < 400 && (i < 12 || orl !== 1'b0 || crl !== 1'b0); i++) @(posedge clk);
        repeat (12) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h95C4));
        rst = 1'b1;
        {wr, rd, stuck, addr, wdata, ap, pm} = '0;
        bad_count = 0;
        n_tests = 0;
        n_to = 0;
        pn = 11'h180;
        dly = 8'h05;
        foreach (e[i]) e[i] = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(bco_pkg::ADDR_CONFIG, v); chk("config", 32'h41, v);
        rd_reg(8'h40, v); chk("unmapped", 32'h0, v);
        chk("cart", 32'(bco_pkg::CART_UNUSED), 32'(cs));
        wr_reg(bco_pkg::ADDR_CONFIG, 32'h4D);
        for (int k = 0; k < 5; k++) for (int c = 0; c < 2 - k / 4; c++) begin
            dly <= 8'($urandom_range(40, 1));
            cmd(k % 4, c); e[c]++;
            chk("status", exp_brk(c), bs);
            chk("final trip", 32'(c == 0), 32'(ft));
            cnts;
        end
        foreach (tb[i]) begin
            pn[tb[i]] <= ~pn[tb[i]];
            cmd(1, 1); e[3]++;
            pn[tb[i]] <= ~pn[tb[i]];
            cnts;
        end
        pn[2] <= 1'b1;
        cmd(1, 0); e[2]++;
        pn[2] <= 1'b0;
        wr_reg(bco_pkg::ADDR_TERMINATE, 32'h3);
        stuck <= 1'b1;
        cmd(3, 1); e[3]++;
        chk("timeouts", 32'h1, 32'(n_to));
        chk("status", exp_brk(0), bs);
        cnts;
        wr_reg(bco_pkg::ADDR_CLEAR, 32'h1);
        repeat (2) @(posedge clk);
        foreach (e[i]) e[i] = 0;
        cnts;
        rd_reg(bco_pkg::ADDR_CLEAR, v); chk("clear", 32'h0, v);
        end_of_test;
    end
    initial begin
        #400000;
        bad_count++;
        end_of_test;
    end
endmodule
